// ---- dhp_buf.sv ----
// constants for the host bus port and its two-entry write buffer
`timescale 1ns/1ns
`default_nettype none

package dhp_pkg;
  localparam int          DW            = 16;         // host data bus width
  localparam int          AW            = 3;          // register address width
  localparam int          BW            = 1 + AW + DW; // buffered word: block, addr, data
  localparam logic        BLK_CMD       = 1'b0;       // command block group
  localparam logic        BLK_CTRL      = 1'b1;       // control block group
  localparam logic [2:0]  ADDR_DATA     = 3'h0;       // data port in command block
  localparam logic [2:0]  ADDR_DRVHEAD  = 3'h6;       // drive/head register
  localparam int          DRV_BIT_POS   = 4;          // drive number bit in drive/head
  localparam int          LOW_BYTE      = 8;          // register accesses use low byte
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          CYC_PER_MS    = CLK_HZ / 1000;
  localparam int          ANNOUNCE_MS   = 400;        // second drive must announce by
  localparam int          DETECT_MS     = 450;        // first drive listening window
  localparam int          RELEASE_MS    = 31000;      // presence timeout
  localparam int          ANNOUNCE_CYC  = ANNOUNCE_MS * CYC_PER_MS;
  localparam int          DETECT_CYC    = DETECT_MS * CYC_PER_MS;
  localparam int          RELEASE_CYC   = RELEASE_MS * CYC_PER_MS;
  localparam int          SYNC_FILL_CYC = 3;          // cycles until strap sync is valid
  localparam int          CW            = 32;         // phase counter width

  typedef enum logic [2:0] {
    DHP_ST_START    = 3'b000,
    DHP_ST_ANNOUNCE = 3'b001,
    DHP_ST_DETECT   = 3'b010,
    DHP_ST_WAIT_NEG = 3'b011,
    DHP_ST_ACTIVITY = 3'b100
  } dhp_phase_e;
endpackage : dhp_pkg

`default_nettype wire

`default_nettype none

// two-entry buffer between the strobe capture and the register file
module dhp_skid #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } dhp_skid_s;

  dhp_skid_s q_reg;
  dhp_skid_s q_next;
  logic      push;
  logic      pop;

  // honest full and empty flags
  assign in_ready  = (q_reg.cnt != 2'h2);
  assign out_valid = (q_reg.cnt != 2'h0);
  assign out_data  = q_reg.mem[q_reg.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and occupancy update
  always_comb begin
    q_next = q_reg;
    if (push) begin
      q_next.mem[q_reg.wp] = in_data;
      q_next.wp            = ~q_reg.wp;
    end
    if (pop) begin
      q_next.rp = ~q_reg.rp;
    end
    if (push && !pop) begin
      q_next.cnt = q_reg.cnt + 2'h1;
    end else if (pop && !push) begin
      q_next.cnt = q_reg.cnt - 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  occupancy_a: assert property (@(posedge clock) disable iff (!resetn)
    q_reg.cnt <= 2'h2) else $error("buffer occupancy above two");
endmodule : dhp_skid

`default_nettype wire

// ---- dhp_port.sv ----
// host bus port of a disk drive: selects, strobes, data bus, presence/activity line
`timescale 1ns/1ns
`default_nettype none

// Contract
// - first chip select routes the access to the command block registers
// - second chip select routes the access to the control block registers
// - second drive asserts presence line within 400 ms of reset release
// - first drive listens for presence up to 450 ms after reset
// - second drive releases presence at first valid command or timeout
// - first drive without second drive may drive line for activity
// - after presence phase ends negated, either drive may signal activity
// - bus is 8 or 16 bits; registers use only low eight bits
// - read strobe falling edge starts driving addressed contents onto bus
// - write strobe rising edge loads bus value into addressed register
// - first/second drive role comes from a static jumper input
// - drive number bit compared with role decides whether drive selected
module dhp_port
  import dhp_pkg::*;
#(
  parameter int DETECT_CYCLES  = dhp_pkg::DETECT_CYC,
  parameter int RELEASE_CYCLES = dhp_pkg::RELEASE_CYC
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  cmd_block_select_n,
  input  wire logic                  ctrl_block_select_n,
  input  wire logic                  reg_addr_bit0,
  input  wire logic                  reg_addr_bit1,
  input  wire logic                  reg_addr_bit2,
  input  wire logic                  read_strobe_n,
  input  wire logic                  write_strobe_n,
  input  wire logic [dhp_pkg::DW-1:0] host_data_bus_in,
  output logic [dhp_pkg::DW-1:0]     host_data_bus_out,
  output logic                       host_data_bus_oe,
  input  wire logic                  present_activity_n_in,
  output logic                       present_activity_n_out,
  output logic                       present_activity_n_oe,
  input  wire logic                  drive_is_second,
  input  wire logic                  data_port_wide,
  input  wire logic                  cmd_accepted,
  input  wire logic                  drive_busy,
  output logic                       rd_req,
  output logic                       rd_block,
  output logic [dhp_pkg::AW-1:0]     rd_addr,
  input  wire logic [dhp_pkg::DW-1:0] rd_data,
  output logic                       wr_valid,
  input  wire logic                  wr_ready,
  output logic                       wr_block,
  output logic [dhp_pkg::AW-1:0]     wr_addr,
  output logic [dhp_pkg::DW-1:0]     wr_data,
  output logic                       drive_selected,
  output logic                       second_present,
  output logic                       role_second
);
  typedef struct packed {
    logic          cs1_s1;
    logic          cs1_s2;
    logic          cs3_s1;
    logic          cs3_s2;
    logic          rd_s1;
    logic          rd_s2;
    logic          rd_s3;
    logic          wr_s1;
    logic          wr_s2;
    logic          wr_s3;
    logic [AW-1:0] a_s1;
    logic [AW-1:0] a_s2;
    logic [DW-1:0] d_s1;
    logic [DW-1:0] d_s2;
    logic          das_s1;
    logic          das_s2;
    logic          role_s1;
    logic          role_s2;
    logic          role;
    dhp_phase_e    st;
    logic [CW-1:0] cnt;
    logic          present;
    logic          drv_bit;
    logic          rd_req;
    logic          rd_blk;
    logic [AW-1:0] rd_a;
    logic          rd_wide;
    logic          rd_on;
    logic [DW-1:0] rd_dat;
    logic          hold_ok;
    logic          hold_blk;
    logic [AW-1:0] hold_a;
    logic [DW-1:0] hold_d;
    logic          pend;
    logic [BW-1:0] pend_w;
  } dhp_port_s;

  dhp_port_s q_reg;
  dhp_port_s q_next;
  logic      cs_any;
  logic      rd_fall;
  logic      wr_rise;
  logic      selected;
  logic      pend_ready;
  logic      das_drive;
  logic      hold_wide;
  logic [BW-1:0] buf_word;

  // strobe edges and decode on synchronised pins
  assign cs_any   = !q_reg.cs1_s2 || !q_reg.cs3_s2;
  assign rd_fall  = q_reg.rd_s3 && !q_reg.rd_s2;
  assign wr_rise  = !q_reg.wr_s3 && q_reg.wr_s2;
  assign selected = (q_reg.drv_bit == q_reg.role);
  assign hold_wide = (q_reg.hold_blk == BLK_CMD) && (q_reg.hold_a == ADDR_DATA) && data_port_wide;

  // presence line: announce, or activity once the presence phase is over
  always_comb begin
    das_drive = 1'b0;
    case (q_reg.st)
      DHP_ST_ANNOUNCE: das_drive = 1'b1;
      DHP_ST_ACTIVITY: das_drive = drive_busy;
      default:         das_drive = 1'b0;
    endcase
  end

  // phase, capture and read path in one next-state block
  always_comb begin
    q_next         = q_reg;
    q_next.cs1_s1  = cmd_block_select_n;
    q_next.cs1_s2  = q_reg.cs1_s1;
    q_next.cs3_s1  = ctrl_block_select_n;
    q_next.cs3_s2  = q_reg.cs3_s1;
    q_next.rd_s1   = read_strobe_n;
    q_next.rd_s2   = q_reg.rd_s1;
    q_next.rd_s3   = q_reg.rd_s2;
    q_next.wr_s1   = write_strobe_n;
    q_next.wr_s2   = q_reg.wr_s1;
    q_next.wr_s3   = q_reg.wr_s2;
    q_next.a_s1    = {reg_addr_bit2, reg_addr_bit1, reg_addr_bit0};
    q_next.a_s2    = q_reg.a_s1;
    q_next.d_s1    = host_data_bus_in;
    q_next.d_s2    = q_reg.d_s1;
    q_next.das_s1  = present_activity_n_in;
    q_next.das_s2  = q_reg.das_s1;
    q_next.role_s1 = drive_is_second;
    q_next.role_s2 = q_reg.role_s1;
    q_next.rd_req  = 1'b0;
    q_next.cnt     = q_reg.cnt + 32'h0000_0001;

    case (q_reg.st)
      DHP_ST_START: begin
        // strap is latched once its synchroniser has filled
        if (q_reg.cnt >= CW'(SYNC_FILL_CYC - 1)) begin
          q_next.role = q_reg.role_s2;
          q_next.cnt  = '0;
          q_next.st   = q_reg.role_s2 ? DHP_ST_ANNOUNCE : DHP_ST_DETECT;
        end
      end
      DHP_ST_ANNOUNCE: begin
        if (cmd_accepted || (q_reg.cnt >= CW'(RELEASE_CYCLES - 1))) begin
          q_next.st = DHP_ST_WAIT_NEG;
        end
      end
      DHP_ST_DETECT: begin
        if (!q_reg.das_s2) begin
          q_next.present = 1'b1;
          q_next.st      = DHP_ST_WAIT_NEG;
        end else if (q_reg.cnt >= CW'(DETECT_CYCLES - 1)) begin
          q_next.st = DHP_ST_ACTIVITY;
        end
      end
      DHP_ST_WAIT_NEG: begin
        if (q_reg.das_s2) begin
          q_next.st = DHP_ST_ACTIVITY;
        end
      end
      DHP_ST_ACTIVITY: q_next.cnt = q_reg.cnt;
      default:         q_next.st  = DHP_ST_START;
    endcase

    // address and data held while the write strobe is low
    if (!q_reg.wr_s2) begin
      q_next.hold_ok  = cs_any;
      q_next.hold_blk = q_reg.cs1_s2 ? BLK_CTRL : BLK_CMD;
      q_next.hold_a   = q_reg.a_s2;
      q_next.hold_d   = q_reg.d_s2;
    end
    if (pend_ready) begin
      q_next.pend = 1'b0;
    end
    if (wr_rise && q_reg.hold_ok) begin
      q_next.pend   = 1'b1;
      q_next.pend_w = {q_reg.hold_blk, q_reg.hold_a,
                       hold_wide ? q_reg.hold_d
                                 : {{(DW-LOW_BYTE){1'b0}}, q_reg.hold_d[LOW_BYTE-1:0]}};
      if ((q_reg.hold_blk == BLK_CMD) && (q_reg.hold_a == ADDR_DRVHEAD)) begin
        q_next.drv_bit = q_reg.hold_d[DRV_BIT_POS];
      end
    end

    // read: request on falling strobe, drive on the following cycle
    if (rd_fall && cs_any && selected) begin
      q_next.rd_req  = 1'b1;
      q_next.rd_blk  = q_reg.cs1_s2 ? BLK_CTRL : BLK_CMD;
      q_next.rd_a    = q_reg.a_s2;
      q_next.rd_wide = q_reg.cs1_s2 ? 1'b0 : ((q_reg.a_s2 == ADDR_DATA) && data_port_wide);
    end
    if (q_reg.rd_req) begin
      q_next.rd_on  = 1'b1;
      q_next.rd_dat = q_reg.rd_wide ? rd_data
                                    : {{(DW-LOW_BYTE){1'b0}}, rd_data[LOW_BYTE-1:0]};
    end
    if (q_reg.rd_s2 || !cs_any) begin
      q_next.rd_on = 1'b0;
    end
  end

  // register the whole state
  always_ff @(posedge clock) begin
    if (!resetn) begin
      q_reg         <= '0;
      q_reg.cs1_s1  <= 1'b1;
      q_reg.cs1_s2  <= 1'b1;
      q_reg.cs3_s1  <= 1'b1;
      q_reg.cs3_s2  <= 1'b1;
      q_reg.rd_s1   <= 1'b1;
      q_reg.rd_s2   <= 1'b1;
      q_reg.rd_s3   <= 1'b1;
      q_reg.wr_s1   <= 1'b1;
      q_reg.wr_s2   <= 1'b1;
      q_reg.wr_s3   <= 1'b1;
      q_reg.das_s1  <= 1'b1;
      q_reg.das_s2  <= 1'b1;
      q_reg.st      <= DHP_ST_START;
    end else begin
      q_reg <= q_next;
    end
  end

  // write words pass the two-entry buffer so a register file stalled for up to three writes loses none
  dhp_skid #(
    .W (BW)
  ) u_wbuf (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (q_reg.pend),
    .in_ready  (pend_ready),
    .in_data   (q_reg.pend_w),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (buf_word)
  );

  // outputs
  assign wr_block               = buf_word[BW-1];
  assign wr_addr                = buf_word[DW +: AW];
  assign wr_data                = buf_word[DW-1:0];
  assign host_data_bus_out      = q_reg.rd_dat;
  assign host_data_bus_oe       = q_reg.rd_on;
  assign present_activity_n_out = 1'b0; // open drain: only pulls low
  assign present_activity_n_oe  = das_drive;
  assign rd_req                 = q_reg.rd_req;
  assign rd_block               = q_reg.rd_blk;
  assign rd_addr                = q_reg.rd_a;
  assign drive_selected         = selected;
  assign second_present         = q_reg.present;
  assign role_second            = q_reg.role;

  // checks on the port's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence read_hit_s;
    rd_fall && cs_any && selected;
  endsequence

  // routing: the select seen at the request edge decides the group
  cmd_route_a: assert property (
    rd_req && (rd_block == BLK_CMD) |-> !$past(q_reg.cs1_s2))
    else $error("command block read without first select");
  ctrl_route_a: assert property (
    rd_req && (rd_block == BLK_CTRL) |-> !$past(q_reg.cs3_s2))
    else $error("control block read without second select");

  // presence phase: start, announce, listen window, release
  announce_start_a: assert property (
    (q_reg.st == DHP_ST_START) |-> ##[1:4] (q_reg.st != DHP_ST_START))
    else $error("presence phase did not start");
  announce_drive_a: assert property (
    (q_reg.st == DHP_ST_ANNOUNCE) |-> present_activity_n_oe)
    else $error("second drive not announcing");
  detect_window_a: assert property (
    (q_reg.st == DHP_ST_DETECT) |-> (q_reg.cnt < CW'(DETECT_CYCLES)))
    else $error("listen window overran");
  release_cmd_a: assert property (
    (q_reg.st == DHP_ST_ANNOUNCE) && cmd_accepted |=> !present_activity_n_oe)
    else $error("presence held after command");
  release_time_a: assert property (
    (q_reg.st == DHP_ST_ANNOUNCE) |-> (q_reg.cnt < CW'(RELEASE_CYCLES)))
    else $error("presence held past timeout");
  activity_drive_a: assert property (
    (q_reg.st == DHP_ST_ACTIVITY) |-> (present_activity_n_oe == drive_busy))
    else $error("activity line does not follow busy");

  // data bus: read drive, write capture, release
  read_drive_a: assert property (
    read_hit_s |-> ##2 (host_data_bus_oe || q_reg.rd_s2 || !cs_any))
    else $error("read did not drive bus");
  write_load_a: assert property (
    wr_rise && q_reg.hold_ok |=> q_reg.pend)
    else $error("write strobe not captured");
  bus_float_a: assert property (
    host_data_bus_oe |-> !$past(q_reg.rd_s2) && selected)
    else $error("bus driven outside a read");
endmodule : dhp_port

`default_nettype wire

// ---- dhp_host_model.sv ----
// host adapter model: selects, address, strobes and write data on the drive port
`timescale 1ns/1ns
`default_nettype none

module dhp_host_model (
  input  wire logic        clock,
  output logic             cs_cmd_n,
  output logic             cs_ctrl_n,
  output logic [2:0]       addr,
  output logic             rd_n,
  output logic             wr_n,
  output logic [15:0]      dq_out,
  output logic             dq_oe,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      last_read
);
  // idle bus: nothing selected, strobes high, data released
  initial begin
    cs_cmd_n  = 1'b1;
    cs_ctrl_n = 1'b1;
    addr      = 3'h0;
    rd_n      = 1'b1;
    wr_n      = 1'b1;
    dq_out    = 16'h0000;
    dq_oe     = 1'b0;
    last_read = 16'h0000;
  end

  // one access: setup, strobe low 8 cycles, hold 4 cycles after the strobe rises
  task automatic access(input logic blk, input logic [2:0] a, input logic wr,
                        input logic [15:0] d);
    @(posedge clock);
    cs_cmd_n  <= blk;
    cs_ctrl_n <= ~blk;
    addr      <= a;
    dq_out    <= d;
    dq_oe     <= wr;
    repeat (2) @(posedge clock);
    rd_n      <= wr;
    wr_n      <= ~wr;
    repeat (8) @(posedge clock);
    last_read <= dq_in;
    rd_n      <= 1'b1;
    wr_n      <= 1'b1;
    repeat (4) @(posedge clock);
    cs_cmd_n  <= 1'b1;
    cs_ctrl_n <= 1'b1;
    dq_oe     <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask : access
endmodule : dhp_host_model

`default_nettype wire

// ---- test_disk_drive_host_bus_port.sv ----
// self-checking bench for the disk drive host bus port
`timescale 1ns/1ns
`default_nettype none

module test_disk_drive_host_bus_port;
  import dhp_pkg::*;
  localparam int DET = 50;
  localparam int REL = 100;
  logic          clock = 1'b0;
  logic          resetn = 1'b0;
  logic          second = 1'b0, wide = 1'b0, cmd_acc = 1'b0, busy = 1'b0;
  logic          other_pull = 1'b0, wr_rdy = 1'b1, flt = 1'b0;
  logic          cs_cmd_n, cs_ctrl_n, rd_n, wr_n, h_oe, d_oe, pa_oe, pa_in, pa_out;
  logic          rd_req, rd_block, wr_valid, wr_block, sel, sec_pres, role;
  logic [2:0]    h_addr;
  logic [AW-1:0] rd_addr, wr_addr;
  logic [DW-1:0] h_dq, h_last, bus, d_out, rd_data, wr_data;
  int            bad_count = 0, n_tests = 0, rd_cnt = 0, oe_cnt = 0, n0, o0;
  logic [19:0]   wq[$];

  always #20 clock = ~clock;

  // wire levels: released data bus toggles, presence line pulled up
  assign bus     = d_oe ? d_out : (h_oe ? h_dq : {16{flt}});
  assign pa_in   = !((pa_oe && !pa_out) || other_pull);
  assign rd_data = {4'hA, 3'h0, rd_block, 5'h05, rd_addr};

  dhp_port #(.DETECT_CYCLES(DET), .RELEASE_CYCLES(REL)) u_dut (
    .clock(clock), .resetn(resetn), .cmd_block_select_n(cs_cmd_n),
    .ctrl_block_select_n(cs_ctrl_n), .reg_addr_bit0(h_addr[0]),
    .reg_addr_bit1(h_addr[1]), .reg_addr_bit2(h_addr[2]), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .host_data_bus_in(bus), .host_data_bus_out(d_out),
    .host_data_bus_oe(d_oe), .present_activity_n_in(pa_in), .present_activity_n_out(pa_out),
    .present_activity_n_oe(pa_oe), .drive_is_second(second), .data_port_wide(wide),
    .cmd_accepted(cmd_acc), .drive_busy(busy), .rd_req(rd_req), .rd_block(rd_block),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_rdy),
    .wr_block(wr_block), .wr_addr(wr_addr), .wr_data(wr_data), .drive_selected(sel),
    .second_present(sec_pres), .role_second(role));

  dhp_host_model u_host (
    .clock(clock), .cs_cmd_n(cs_cmd_n), .cs_ctrl_n(cs_ctrl_n), .addr(h_addr),
    .rd_n(rd_n), .wr_n(wr_n), .dq_out(h_dq), .dq_oe(h_oe), .dq_in(bus), .last_read(h_last));

  // monitor: read pulses, driven cycles, words taken from the buffer
  always @(posedge clock) begin
    flt <= ~flt;
    if (rd_req) rd_cnt <= rd_cnt + 1;
    if (d_oe) oe_cnt <= oe_cnt + 1;
    if (wr_valid && wr_rdy) wq.push_back({wr_block, wr_addr, wr_data});
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic do_reset(input logic sec);
    @(posedge clock);
    second <= sec;
    resetn <= 1'b0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
  endtask : do_reset

  task automatic set_busy(input logic b);
    @(posedge clock);
    busy <= b;
  endtask : set_busy

  // first drive alone: no announce seen, then activity
  task automatic t_first_alone();
    do_reset(1'b0);
    tick(DET + 10);
    check(sec_pres, 1'b0);
    check(role, 1'b0);
    set_busy(1'b1);
    tick(3);
    check({pa_oe, pa_in}, 2'b10);
    set_busy(1'b0);
    tick(2);
    check(pa_oe, 1'b0);
  endtask : t_first_alone

  // first drive hears the other drive announce some 20 cycles into the 50-cycle window
  task automatic t_second_seen();
    do_reset(1'b0);
    tick(20);
    @(posedge clock);
    other_pull <= 1'b1;
    tick(15);
    @(posedge clock);
    other_pull <= 1'b0;
    tick(DET);
    check(sec_pres, 1'b1);
    set_busy(1'b1);
    tick(3);
    check(pa_oe, 1'b1);
    set_busy(1'b0);
  endtask : t_second_seen

  // second drive: announce, release on command, then on timeout
  task automatic t_second_drive();
    do_reset(1'b1);
    tick(6);
    check(role, 1'b1);
    check({pa_oe, pa_in}, 2'b10);
    @(posedge clock);
    cmd_acc <= 1'b1;
    @(posedge clock);
    cmd_acc <= 1'b0;
    tick(3);
    check(pa_oe, 1'b0);
    set_busy(1'b1);
    tick(3);
    check(pa_oe, 1'b1);
    set_busy(1'b0);
    do_reset(1'b1);
    tick(REL - 10);
    check(pa_oe, 1'b1);
    tick(20);
    check(pa_oe, 1'b0);
  endtask : t_second_drive

  // reads of command block registers 1 to 7, control block registers 6 and 7, the data port, and an unselected drive
  task automatic t_reads();
    logic       blk;
    logic [2:0] a;
    do_reset(1'b0);
    u_host.access(1'b0, ADDR_DRVHEAD, 1'b1, 16'h00E0);
    tick(2);
    check(sel, 1'b1);
    for (int i = 1; i < 10; i++) begin
      blk = (i > 7);
      a = (i > 7) ? 3'(i - 2) : 3'(i);
      n0 = rd_cnt;
      u_host.access(blk, a, 1'b0, 16'h0000);
      check(h_last, {8'h00, 5'h05, a});
      check({rd_block, rd_addr}, {blk, a});
      check(rd_cnt - n0, 1);
      check(d_oe, 1'b0);
    end
    for (int w = 1; w >= 0; w--) begin
      @(posedge clock);
      wide <= w[0];
      u_host.access(1'b0, ADDR_DATA, 1'b0, 16'h0000);
      check(h_last, w[0] ? 16'hA028 : 16'h0028);
    end
    u_host.access(1'b0, ADDR_DRVHEAD, 1'b1, 16'h00F0);
    tick(2);
    check(sel, 1'b0);
    n0 = rd_cnt;
    o0 = oe_cnt;
    u_host.access(1'b0, 3'h1, 1'b0, 16'h0000);
    check(rd_cnt - n0, 0);
    check(oe_cnt - o0, 0);
  endtask : t_reads

  // writes to both groups and the data port, then two words held by a stall
  task automatic t_writes();
    wq.delete();
    u_host.access(1'b0, 3'h2, 1'b1, 16'hBEEF);
    u_host.access(1'b1, 3'h6, 1'b1, 16'h1234);
    @(posedge clock);
    wide <= 1'b1;
    u_host.access(1'b0, ADDR_DATA, 1'b1, 16'hBEEF);
    tick(4);
    check(wq.size(), 3);
    check(wq[0], {1'b0, 3'h2, 16'h00EF});
    check(wq[1], {1'b1, 3'h6, 16'h0034});
    check(wq[2], {1'b0, 3'h0, 16'hBEEF});
    wq.delete();
    @(posedge clock);
    wr_rdy <= 1'b0;
    u_host.access(1'b0, 3'h3, 1'b1, 16'h0011);
    u_host.access(1'b0, 3'h4, 1'b1, 16'h0022);
    tick(2);
    check(wq.size(), 0);
    check(wr_valid, 1'b1);
    @(posedge clock);
    wr_rdy <= 1'b1;
    tick(4);
    check(wq.size(), 2);
    check(wq[0], {1'b0, 3'h3, 16'h0011});
    check(wq[1], {1'b0, 3'h4, 16'h0022});
  endtask : t_writes

  task automatic close_out();
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // main sequence
  initial begin
    t_first_alone();
    t_second_seen();
    t_second_drive();
    t_reads();
    t_writes();
    close_out();
  end

  // watchdog, about ten times the expected run
  initial begin
    repeat (8000) @(posedge clock);
    bad_count++;
    close_out();
  end
endmodule : test_disk_drive_host_bus_port

`default_nettype wire
